// ---- rtl/llx_core.sv ----
`include "llx_consts.svh"

module llx_core #(
  parameter int AREA_TUNING_LEVEL    = 0,
  parameter bit BYTE_SWAP_OPTION     = 1'b1,
  parameter bit PATTERN_MATCH_OPTION = 1'b1
) (
  // apb
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // data memory through translation
  output logic             mem_req,
  output logic      [63:0] mem_addr,
  input  wire logic        mem_miss,
  input  wire logic        mem_denied,
  input  wire logic [63:0] mem_rdata
);
  // elaboration stops on a tuning level that the sequencer cannot count
  if (AREA_TUNING_LEVEL < 0 || AREA_TUNING_LEVEL > 2) begin : g_bad_level
    $error("area tuning level must be 0, 1 or 2");
  end

  localparam logic [1:0] LOAD_LAT = (AREA_TUNING_LEVEL == 1) ? 2'(`LLX_LAT_LOAD_SLOW)
                                                             : 2'(`LLX_LAT_LOAD_FAST);

  // software-visible state, sequencer state and output flops
  logic [31:0] instr_reg;
  logic [63:0] opa_reg, opb_reg, opd_reg, res_reg;
  logic [31:0] pfx_reg;
  logic [7:0]  machine_state_reg;
  logic [12:0] exception_status_reg;
  logic [4:0]  status_reg;
  logic        go_reg;
  logic [1:0]  cnt_reg;
  llx_pkg::llx_state_type state_reg;
  logic [31:0] prdata_reg;
  logic        pready_reg, pslverr_reg;
  logic        mem_req_q;
  logic [63:0] mem_addr_q;

  // instruction decode: [3:0] op, [8:4] dest index, 9 keep, 10 use carry
  wire logic [3:0]  op_code   = instr_reg[3:0];
  wire logic [4:0]  dest_idx  = instr_reg[8:4];
  wire logic        keep_c    = instr_reg[9];
  wire logic        use_c     = instr_reg[10];
  wire logic [15:0] imm16     = instr_reg[31:16];
  wire logic [1:0]  pfx_cnt   = pfx_reg[`LLX_PFX_VALID_LSB +: 2];
  wire logic [23:0] pfx_val   = pfx_reg[23:0];

  // constant formation
  wire logic [63:0] imm_sext  = {{48{imm16[15]}}, imm16};
  wire logic [39:0] imm40     = {pfx_val, imm16};
  wire logic [63:0] imm_ext   = (pfx_cnt == 2'h0) ? imm_sext
                              : {{24{imm40[39]}}, imm40};

  wire logic is_load   = (op_code <= 4'h2);
  wire logic is_pcmp   = (op_code >= 4'h6) && (op_code <= 4'h8);
  wire logic illegal   = (op_code > 4'h9)
                       || (op_code == 4'h1 && !BYTE_SWAP_OPTION)
                       || (is_pcmp && !PATTERN_MATCH_OPTION);
  wire logic [63:0] ld_addr = (op_code == 4'h2) ? opa_reg + imm_ext
                                                : opa_reg + opb_reg;

  // bus decode
  wire logic        apb_acc = psel && penable && !pready_reg;
  wire logic        apb_wr  = apb_acc && pwrite;
  wire logic        apb_rd  = apb_acc && !pwrite;
  wire logic        hit     = (paddr <= `LLX_OFF_PFX) && (paddr[1:0] == 2'b00);
  wire logic        busy    = (state_reg != llx_pkg::LLX_IDLE);
  wire logic        start   = go_reg && !busy;

  // alu
  logic [63:0] alu_res;
  logic        alu_carry;
  llx_alu u_alu (
    .op        (op_code),
    .opa       (opa_reg),
    .opb       (opb_reg),
    .opd       (opd_reg),
    .imm       (imm_ext),
    .carry_in  (machine_state_reg[`LLX_MST_CARRY]),
    .use_carry (use_c),
    .result    (alu_res),
    .carry_out (alu_carry)
  );

  // translation and memory
  llx_mem_if   mif ();
  logic        x_miss, x_denied;
  logic [63:0] x_data;
  wire  logic  ld_start = start && is_load && !illegal;
  llx_xlat u_xlat (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (ld_start),
    .addr    (ld_addr),
    .swap    (op_code == 4'h1),
    .mem     (mif.core),
    .miss    (x_miss),
    .denied  (x_denied),
    .data    (x_data)
  );
  assign mif.miss   = mem_miss;
  assign mif.denied = mem_denied;
  assign mif.rdata  = mem_rdata;

  wire logic user_privilege_flag  = machine_state_reg[`LLX_MST_USER];
  wire logic virtual_protect_flag = machine_state_reg[`LLX_MST_VIRT];
  wire logic f_miss  = virtual_protect_flag && x_miss;
  wire logic f_zone  = !f_miss && user_privilege_flag && virtual_protect_flag
                       && x_denied;
  wire logic f_align = !f_miss && !f_zone && (mem_addr_q[2:0] != 3'h0);

  function automatic logic [31:0] rd_mux(input logic [11:0] a);
    case (a)
      `LLX_OFF_CTRL:   rd_mux = {31'h0, go_reg};
      `LLX_OFF_INSTR:  rd_mux = instr_reg;
      `LLX_OFF_OPA_LO: rd_mux = opa_reg[31:0];
      `LLX_OFF_OPA_HI: rd_mux = opa_reg[63:32];
      `LLX_OFF_OPB_LO: rd_mux = opb_reg[31:0];
      `LLX_OFF_OPB_HI: rd_mux = opb_reg[63:32];
      `LLX_OFF_OPD_LO: rd_mux = opd_reg[31:0];
      `LLX_OFF_OPD_HI: rd_mux = opd_reg[63:32];
      `LLX_OFF_RES_LO: rd_mux = res_reg[31:0];
      `LLX_OFF_RES_HI: rd_mux = res_reg[63:32];
      `LLX_OFF_STATUS: rd_mux = {27'h0, status_reg};
      `LLX_OFF_XSTAT:  rd_mux = {19'h0, exception_status_reg};
      `LLX_OFF_MSTATE: rd_mux = {24'h0, machine_state_reg};
      `LLX_OFF_PFX:    rd_mux = pfx_reg;
      default:         rd_mux = 32'h0;
    endcase
  endfunction : rd_mux

  // apb slave; one wait state, so every access ends two cycles after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= `LLX_RESET_VAL;
    end else begin
      pready_reg  <= apb_acc;
      pslverr_reg <= apb_acc && !hit;
      prdata_reg  <= apb_rd ? rd_mux(paddr) : 32'h0;
    end
  end

  // operand and instruction registers; writes while busy are dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_reg <= `LLX_RESET_VAL;
      opa_reg   <= 64'h0;
      opb_reg   <= 64'h0;
      opd_reg   <= 64'h0;
      pfx_reg   <= `LLX_RESET_VAL;
      go_reg    <= 1'b0;
    end else begin
      go_reg <= apb_wr && !busy && paddr == `LLX_OFF_CTRL && pwdata[`LLX_CTRL_GO];
      if (apb_wr && !busy) begin
        case (paddr)
          `LLX_OFF_INSTR:  instr_reg      <= pwdata;
          `LLX_OFF_OPA_LO: opa_reg[31:0]  <= pwdata;
          `LLX_OFF_OPA_HI: opa_reg[63:32] <= pwdata;
          `LLX_OFF_OPB_LO: opb_reg[31:0]  <= pwdata;
          `LLX_OFF_OPB_HI: opb_reg[63:32] <= pwdata;
          `LLX_OFF_OPD_LO: opd_reg[31:0]  <= pwdata;
          `LLX_OFF_OPD_HI: opd_reg[63:32] <= pwdata;
          `LLX_OFF_PFX:    pfx_reg        <= pwdata;
          default:         pfx_reg        <= pfx_reg;
        endcase
      end else if (start) begin
        pfx_reg <= {8'h0, pfx_reg[23:0]}; // prefix is consumed by the next instruction
      end
    end
  end

  // execution sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg  <= llx_pkg::LLX_IDLE;
      cnt_reg    <= 2'h0;
      res_reg    <= 64'h0;
      machine_state_reg    <= 8'h0;
      exception_status_reg <= 13'h0;
      status_reg <= 5'h0;
      mem_req_q  <= 1'b0;
      mem_addr_q <= 64'h0;
    end else begin
      mem_req_q  <= mif.req;
      mem_addr_q <= mif.addr;
      if (apb_wr && !busy && paddr == `LLX_OFF_MSTATE) begin
        machine_state_reg <= pwdata[7:0];
      end
      case (state_reg)
        llx_pkg::LLX_IDLE: begin
          if (start) begin
            status_reg <= 5'h1;
            if (illegal) begin
              status_reg <= 5'b01010;
            end else if (is_load) begin
              state_reg <= llx_pkg::LLX_XLAT;
              cnt_reg   <= LOAD_LAT - 2'h1;
            end else begin
              res_reg    <= alu_res;
              status_reg <= 5'b10010;
              if (op_code == 4'h9 && !keep_c) begin
                machine_state_reg[`LLX_MST_CARRY] <= alu_carry;
              end
            end
          end
        end
        llx_pkg::LLX_XLAT: begin
          cnt_reg <= cnt_reg - 2'h1;
          if (cnt_reg == 2'h1) begin
            state_reg <= llx_pkg::LLX_DONE;
          end
        end
        llx_pkg::LLX_DONE: begin
          state_reg <= llx_pkg::LLX_IDLE;
          if (f_miss) begin
            exception_status_reg <= {7'h0, 1'b0, `LLX_CAUSE_MISS};
            machine_state_reg[`LLX_MST_USER_SV] <= user_privilege_flag;
            machine_state_reg[`LLX_MST_VIRT_SV] <= virtual_protect_flag;
            machine_state_reg[`LLX_MST_USER]    <= 1'b0;
            machine_state_reg[`LLX_MST_VIRT]    <= 1'b0;
            status_reg <= 5'b00110;
          end else if (f_zone) begin
            exception_status_reg <= {5'h0, 1'b0, 1'b1, 1'b0, `LLX_CAUSE_ZONE};
            machine_state_reg[`LLX_MST_USER_SV] <= user_privilege_flag;
            machine_state_reg[`LLX_MST_USER]    <= 1'b0;
            machine_state_reg[`LLX_MST_VIRT]    <= 1'b0;
            status_reg <= 5'b00110;
          end else if (f_align) begin
            exception_status_reg <= {dest_idx, 1'b1, 1'b0, 1'b0, `LLX_CAUSE_ALIGN};
            status_reg <= 5'b00110;
          end else begin
            res_reg    <= x_data;
            status_reg <= 5'b10010;
          end
        end
        default: state_reg <= llx_pkg::LLX_IDLE;
      endcase
    end
  end

  // the load request leaves through a flop so top outputs stay registered
  assign prdata   = prdata_reg;
  assign pready   = pready_reg;
  assign pslverr  = pslverr_reg;
  assign mem_req  = mem_req_q;
  assign mem_addr = mem_addr_q;
endmodule : llx_core

// ---- rtl/llx_consts.svh ----
`ifndef LLX_CONSTS_SVH
`define LLX_CONSTS_SVH
// apb register byte offsets
`define LLX_OFF_CTRL      12'h000
`define LLX_OFF_INSTR     12'h004
`define LLX_OFF_OPA_LO    12'h008
`define LLX_OFF_OPA_HI    12'h00c
`define LLX_OFF_OPB_LO    12'h010
`define LLX_OFF_OPB_HI    12'h014
`define LLX_OFF_OPD_LO    12'h018
`define LLX_OFF_OPD_HI    12'h01c
`define LLX_OFF_RES_LO    12'h020
`define LLX_OFF_RES_HI    12'h024
`define LLX_OFF_STATUS    12'h028
`define LLX_OFF_XSTAT     12'h02c
`define LLX_OFF_MSTATE    12'h030
`define LLX_OFF_PFX       12'h034
// control register fields
`define LLX_CTRL_GO       0
// status register fields
`define LLX_ST_BUSY       0
`define LLX_ST_DONE       1
`define LLX_ST_EXC        2
`define LLX_ST_ILLEGAL    3
`define LLX_ST_WROTE      4
// machine state fields
`define LLX_MST_CARRY     0
`define LLX_MST_USER      1
`define LLX_MST_VIRT      2
`define LLX_MST_USER_SV   3
`define LLX_MST_VIRT_SV   4
// exception status fields
`define LLX_XST_CAUSE_LSB 0
`define LLX_XST_STORE     5
`define LLX_XST_ZONE      6
`define LLX_XST_WIDE      7
`define LLX_XST_DEST_LSB  8
// cause codes
`define LLX_CAUSE_MISS    5'h12
`define LLX_CAUSE_ZONE    5'h10
`define LLX_CAUSE_ALIGN   5'h01
// prefix control fields
`define LLX_PFX_VALID_LSB 24
// latency in cycles
`define LLX_LAT_LOAD_FAST 2
`define LLX_LAT_LOAD_SLOW 3
`define LLX_RESET_VAL     32'h0000_0000
`endif

// ---- rtl/llx_pkg.sv ----
package llx_pkg;
  typedef enum logic [3:0] {
    LLX_OP_LOAD_IDX  = 4'h0,
    LLX_OP_LOAD_SWP  = 4'h1,
    LLX_OP_LOAD_OFS  = 4'h2,
    LLX_OP_OR_REG    = 4'h3,
    LLX_OP_OR_IMM    = 4'h4,
    LLX_OP_OR_IMM2   = 4'h5,
    LLX_OP_PCMP_BF   = 4'h6,
    LLX_OP_PCMP_EQ   = 4'h7,
    LLX_OP_PCMP_NE   = 4'h8,
    LLX_OP_RSUB      = 4'h9
  } llx_op_type;

  typedef enum logic [1:0] {
    LLX_IDLE = 2'b00,
    LLX_XLAT = 2'b01,
    LLX_MEM  = 2'b10,
    LLX_DONE = 2'b11
  } llx_state_type;
endpackage : llx_pkg

// ---- rtl/llx_mem_if.sv ----
interface llx_mem_if;
  logic        req;
  logic [63:0] addr;
  logic        miss;
  logic        denied;
  logic [63:0] rdata;
  modport core (output req, output addr, input miss, input denied, input rdata);
  modport mem  (input req, input addr, output miss, output denied, output rdata);
endinterface : llx_mem_if

// ---- rtl/llx_alu.sv ----
module llx_alu (
  // operands
  input  wire logic [3:0]  op,
  input  wire logic [63:0] opa,
  input  wire logic [63:0] opb,
  input  wire logic [63:0] opd,
  input  wire logic [63:0] imm,
  input  wire logic        carry_in,
  input  wire logic        use_carry,
  // results
  output logic      [63:0] result,
  output logic             carry_out
);
  function automatic logic [63:0] byte_find(input logic [63:0] a, input logic [63:0] b);
    logic [63:0] pos;
    pos = 64'h0;
    for (int i = 7; i >= 0; i--) begin
      if (a[i*8 +: 8] == b[i*8 +: 8] && pos == 64'h0) begin
        pos = 64'(8 - i);
      end
    end
    return pos;
  endfunction : byte_find

  wire logic [64:0] rsub_sum = {1'b0, opb} + {1'b0, ~opa} + {64'h0, (use_carry ? carry_in : 1'b1)};
  wire logic        same     = (opa == opb);

  always_comb begin
    carry_out = rsub_sum[64];
    case (op)
      4'h3:    result = opa | opb;
      4'h4:    result = opa | imm;
      4'h5:    result = opd | imm;
      4'h6:    result = byte_find(opa, opb);
      4'h7:    result = {63'h0, same};
      4'h8:    result = {63'h0, ~same};
      4'h9:    result = rsub_sum[63:0];
      default: result = 64'h0;
    endcase
  end
endmodule : llx_alu

// ---- rtl/llx_xlat.sv ----
module llx_xlat (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // start
  input  wire logic        start,
  input  wire logic [63:0] addr,
  input  wire logic        swap,
  // memory side
  llx_mem_if.core          mem,
  // outcome
  output logic             miss,
  output logic             denied,
  output logic [63:0]      data
);
  logic [63:0] addr_reg;
  logic        req_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_reg <= 64'h0;
      req_reg  <= 1'b0;
    end else begin
      req_reg  <= start;
      if (start) begin
        addr_reg <= addr;
      end
    end
  end

  assign mem.req  = req_reg;
  assign mem.addr = addr_reg;
  assign miss     = mem.miss;
  assign denied   = mem.denied;

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_swap
      assign data[g*8 +: 8] = swap ? mem.rdata[(7-g)*8 +: 8] : mem.rdata[g*8 +: 8];
    end
  endgenerate
endmodule : llx_xlat

// ---- bench/llx_mem_model.sv ----
module llx_mem_model (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // load request
  input  wire logic        mem_req,
  input  wire logic [63:0] mem_addr,
  // fault controls
  input  wire logic        miss_cfg,
  input  wire logic        deny_cfg,
  // answer
  output logic             mem_miss,
  output logic             mem_denied,
  output logic      [63:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [63:0] addr_reg;
  logic [2:0]  hold_reg;
  // answer held a few cycles past the request, scrambled after that
  wire         live = mem_req || (hold_reg != 3'h0);
  wire  [63:0] sel  = mem_req ? mem_addr : addr_reg;
  wire  [63:0] word = {sel[31:0] ^ 32'h0f1e2d3c, ~sel[31:0]};
  assign mem_rdata  = live ? word : ~word;
  assign mem_miss   = live ? miss_cfg : ~miss_cfg;
  assign mem_denied = live ? deny_cfg : ~deny_cfg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_reg <= 64'h0;
      hold_reg <= 3'h0;
    end else if (mem_req) begin
      addr_reg <= mem_addr;
      hold_reg <= 3'h5;
    end else if (hold_reg != 3'h0) begin
      hold_reg <= hold_reg - 3'h1;
    end
  end
endmodule : llx_mem_model

// ---- bench/llx_core_assertions.sv ----
module llx_core_checker (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // memory side
  input wire logic        mem_req
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire bad_addr = (paddr > 12'h034) || (paddr[1:0] != 2'b00);
  sequence s_take;
    psel && penable && !pready;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence
  property p_answer;
    s_take |=> s_answer;
  endproperty
  a_answer: assert property (p_answer) else $error("ready not one cycle after access");
  property p_cause;
    pready |-> $past(psel) && $past(penable);
  endproperty
  a_cause: assert property (p_cause) else $error("ready without access");
  property p_refuse;
    s_take ##0 bad_addr |=> pslverr && prdata == 32'h0;
  endproperty
  a_refuse: assert property (p_refuse) else $error("unmapped access not refused");
  property p_accept;
    s_take ##0 !bad_addr |=> !pslverr;
  endproperty
  a_accept: assert property (p_accept) else $error("mapped access refused");
  property p_quiet;
    !pready |-> prdata == 32'h0;
  endproperty
  a_quiet: assert property (p_quiet) else $error("read data outside answer");
  property p_err_lone;
    pslverr |-> pready;
  endproperty
  a_err_lone: assert property (p_err_lone) else $error("error without ready");
  // a new load needs several bus cycles, so requests never crowd
  property p_req_gap;
    mem_req |=> !mem_req [*3];
  endproperty
  a_req_gap: assert property (p_req_gap) else $error("load requests too close");
  property p_reset;
    $rose(presetn) |-> !pready && !mem_req;
  endproperty
  a_reset: assert property (p_reset) else $error("outputs busy after reset");
endmodule : llx_core_checker

bind llx_core llx_core_checker chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .mem_req(mem_req));

// ---- bench/long_load_or_compare_subtract_bench.sv ----
`include "llx_consts.svh"
module long_load_or_compare_subtract_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic        miss_cfg = 1'b0;
  logic        deny_cfg = 1'b0;
  logic [31:0] prdata;
  logic        pready, pslverr, mem_req, mem_miss, mem_denied;
  logic [63:0] mem_addr, mem_rdata;
  int          err_total = 0;
  int          comparisons = 0;
  logic        last_err = 1'b0;
  localparam logic [63:0] PA = 64'h1122_3344_5566_7788;
  always #2.5 pclk = ~pclk;
  llx_core dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_req(mem_req), .mem_addr(mem_addr), .mem_miss(mem_miss),
    .mem_denied(mem_denied), .mem_rdata(mem_rdata));
  llx_mem_model mem_u (.pclk(pclk), .presetn(presetn), .mem_req(mem_req),
    .mem_addr(mem_addr), .miss_cfg(miss_cfg), .deny_cfg(deny_cfg), .mem_miss(mem_miss),
    .mem_denied(mem_denied), .mem_rdata(mem_rdata));
  task automatic give_verdict();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict
  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic timed_out(input int n);
    if (n >= 20) begin
      err_total++;
      give_verdict();
    end
  endtask : timed_out
  // entered just after a rising edge; ends one idle edge after release
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    timed_out(n);
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask : wr
  task automatic wr64(input logic [11:0] a, input logic [63:0] v);
    wr(a, v[31:0]);
    wr(a + 12'h004, v[63:32]);
  endtask : wr64
  task automatic rd64(input logic [11:0] a, output logic [63:0] v);
    logic [31:0] lo, hi;
    apb(1'b0, a, 32'h0, lo);
    apb(1'b0, a + 12'h004, 32'h0, hi);
    v = {hi, lo};
  endtask : rd64
  function automatic logic [31:0] ins(input llx_pkg::llx_op_type op, input logic [4:0] dst,
                                      input logic k, input logic c, input logic [15:0] imm);
    return {imm, 5'h00, c, k, dst, op};
  endfunction : ins
  function automatic logic [63:0] memv(input logic [63:0] a);
    return {a[31:0] ^ 32'h0f1e2d3c, ~a[31:0]};
  endfunction : memv
  task automatic op_chk(input string name, input logic [31:0] iw, input logic [63:0] a,
                        input logic [63:0] b, input logic [63:0] d, input logic [63:0] exp);
    logic [31:0] st;
    logic [63:0] r;
    int n;
    n = 0;
    wr64(`LLX_OFF_OPA_LO, a);
    wr64(`LLX_OFF_OPB_LO, b);
    wr64(`LLX_OFF_OPD_LO, d);
    wr(`LLX_OFF_INSTR, iw);
    wr(`LLX_OFF_CTRL, 32'h1);
    do begin
      apb(1'b0, `LLX_OFF_STATUS, 32'h0, st);
      n++;
    end while (st[`LLX_ST_BUSY] !== 1'b0 && n < 20);
    timed_out(n);
    rd64(`LLX_OFF_RES_LO, r);
    check(name, r, exp);
  endtask : op_chk
  task automatic rsub(input logic [63:0] a, input logic [63:0] b, input logic k,
                      input logic c, input logic [63:0] exp, input logic expc);
    logic [31:0] m;
    op_chk("rsub", ins(llx_pkg::LLX_OP_RSUB, 5'd3, k, c, 16'h0), a, b, 64'h0, exp);
    apb(1'b0, `LLX_OFF_MSTATE, 32'h0, m);
    check("carry", {63'h0, m[`LLX_MST_CARRY]}, {63'h0, expc});
  endtask : rsub
  // restarts the block, then one offset load at address a
  task automatic fault(input logic [31:0] mst, input logic ms, input logic dn,
                       input logic [63:0] a, input logic [31:0] xst_x, input logic [31:0] mst_x);
    logic [31:0] q;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    miss_cfg <= ms;
    deny_cfg <= dn;
    @(posedge pclk);
    wr(`LLX_OFF_MSTATE, mst);
    op_chk("dest", ins(llx_pkg::LLX_OP_LOAD_OFS, 5'd5, 1'b0, 1'b0, 16'h0), a, 64'h0, 64'h0,
           xst_x == 32'h0 ? memv(a) : 64'h0);
    apb(1'b0, `LLX_OFF_XSTAT, 32'h0, q);
    check("cause", {32'h0, q}, {32'h0, xst_x});
    apb(1'b0, `LLX_OFF_MSTATE, 32'h0, q);
    check("state", {32'h0, q}, {32'h0, mst_x});
  endtask : fault
  // unmapped address and an undecoded operation code are both turned away
  task automatic refusals();
    logic [31:0] q;
    apb(1'b0, 12'h040, 32'h0, q);
    check("unmapped", {32'h0, q}, 64'h0);
    check("unmapped err", {63'h0, last_err}, 64'h1);
    wr(`LLX_OFF_INSTR, 32'h0000_000a);
    wr(`LLX_OFF_CTRL, 32'h1);
    apb(1'b0, `LLX_OFF_STATUS, 32'h0, q);
    check("illegal", {63'h0, q[`LLX_ST_ILLEGAL]}, 64'h1);
    check("mapped err", {63'h0, last_err}, 64'h0);
  endtask : refusals
  initial begin
    logic [63:0] x;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    op_chk("or", ins(llx_pkg::LLX_OP_OR_REG, 5'd1, 1'b0, 1'b0, 16'h0), PA, 64'hf0, 64'h0,
           PA | 64'hf0);
    wr(`LLX_OFF_PFX, 32'h0100_0012);
    op_chk("ori a", ins(llx_pkg::LLX_OP_OR_IMM, 5'd1, 1'b0, 1'b0, 16'h8001), 64'h4, 64'h0,
           64'h0, 64'h0000_0000_0012_8005);
    wr(`LLX_OFF_PFX, 32'h0180_0000);
    op_chk("ori d", ins(llx_pkg::LLX_OP_OR_IMM2, 5'd1, 1'b0, 1'b0, 16'h0003), 64'h0, 64'h0,
           64'h100, 64'hffff_ff80_0000_0103);
    op_chk("ori s", ins(llx_pkg::LLX_OP_OR_IMM2, 5'd1, 1'b0, 1'b0, 16'h8000), 64'h0, 64'h0,
           64'h1, 64'hffff_ffff_ffff_8001);
    op_chk("bf1", ins(llx_pkg::LLX_OP_PCMP_BF, 5'd2, 1'b0, 1'b0, 16'h0), PA, PA, 64'h0,
           64'h1);
    op_chk("bf8", ins(llx_pkg::LLX_OP_PCMP_BF, 5'd2, 1'b0, 1'b0, 16'h0), PA,
           PA ^ 64'hffff_ffff_ffff_ff00, 64'h0, 64'h8);
    op_chk("bf5", ins(llx_pkg::LLX_OP_PCMP_BF, 5'd2, 1'b0, 1'b0, 16'h0), PA,
           PA ^ 64'hffff_ffff_00ff_ffff, 64'h0, 64'h5);
    op_chk("bf0", ins(llx_pkg::LLX_OP_PCMP_BF, 5'd2, 1'b0, 1'b0, 16'h0), PA, ~PA, 64'h0,
           64'h0);
    for (int i = 0; i < 4; i++) begin
      op_chk("cmp", ins(i < 2 ? llx_pkg::LLX_OP_PCMP_EQ : llx_pkg::LLX_OP_PCMP_NE, 5'd4, 1'b0,
             1'b0, 16'h0), PA, PA ^ 64'(i % 2), 64'h0, 64'((i % 2) ^ (i / 2) ^ 1));
    end
    rsub(64'h3, 64'h5, 1'b0, 1'b0, 64'h2, 1'b1);
    rsub(64'h5, 64'h3, 1'b1, 1'b1, 64'hffff_ffff_ffff_fffe, 1'b1);
    rsub(64'h5, 64'h3, 1'b0, 1'b0, 64'hffff_ffff_ffff_fffe, 1'b0);
    rsub(64'h3, 64'h5, 1'b1, 1'b1, 64'h1, 1'b0);
    op_chk("ldo", ins(llx_pkg::LLX_OP_LOAD_OFS, 5'd2, 1'b0, 1'b0, 16'hfff8), 64'h1000, 64'h0,
           64'h0, memv(64'h0ff8));
    x = memv(64'h2040);
    op_chk("ldi", ins(llx_pkg::LLX_OP_LOAD_IDX, 5'd2, 1'b0, 1'b0, 16'h0), 64'h2000, 64'h40,
           64'h0, x);
    x = {<<8{x}};
    op_chk("lds", ins(llx_pkg::LLX_OP_LOAD_SWP, 5'd2, 1'b0, 1'b0, 16'h0), 64'h2000, 64'h40,
           64'h0, x);
    refusals();
    fault(32'h6, 1'b1, 1'b1, 64'h1001, 32'h12, 32'h18);
    fault(32'h6, 1'b0, 1'b1, 64'h1001, 32'h50, 32'h08);
    fault(32'h0, 1'b1, 1'b1, 64'h1001, 32'h581, 32'h0);
    fault(32'h2, 1'b0, 1'b1, 64'h1008, 32'h0, 32'h2);
    give_verdict();
  end
endmodule : long_load_or_compare_subtract_bench
